// ==== src/btg_defs.svh ====
// register map, reset values and timing counts of the beep tone generator
`ifndef BTG_DEFS_SVH
`define BTG_DEFS_SVH
`define BTG_A_LCTL 8'h47
`define BTG_A_RCTL 8'h48
`define BTG_A_LEN_H 8'h49
`define BTG_A_LEN_M 8'h4A
`define BTG_A_LEN_L 8'h4B
`define BTG_A_SIN_H 8'h4C
`define BTG_A_SIN_L 8'h4D
`define BTG_A_COS_H 8'h4E
`define BTG_A_COS_L 8'h4F
`define BTG_A_ROUTE 8'h3F
`define BTG_R_LEN_L 8'hEE
`define BTG_R_SIN_H 8'h10
`define BTG_R_SIN_L 8'hD8
`define BTG_R_COS_H 8'h7E
`define BTG_R_COS_L 8'hE3
`define BTG_R_ZERO 8'h00
`define BTG_EN_BIT 7
`define BTG_ROUTE_LO 4
`define BTG_ROUTE_HI 5
`define BTG_ONE_Q15 16'sh7FFF
`define BTG_VOL_FRAC 14
`define BTG_STEPS_OCT 6
`define BTG_MASTER_STEP 1
`define BTG_PASS_COEF 24'h7FFFFF
`define BTG_TAPS 5
`define BTG_CLK_MHZ 10
`define BTG_BOOT_US 100
`define BTG_BOOT_CYC (`BTG_BOOT_US * `BTG_CLK_MHZ)
`define BTG_SAMPLE_DIV 208
`endif

// ==== src/btg_pkg.sv ====
// types shared by the beep tone generator
`default_nettype none
package btg_pkg;
	typedef enum logic [2:0] {
		BTG_BOOT_COPY = 3'h1,
		BTG_BOOT_WAIT = 3'h2,
		BTG_BOOT_DONE = 3'h4
	} btg_boot_t;

	typedef struct packed {
		logic signed [15:0] left;
		logic signed [15:0] right;
	} btg_play_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} btg_regreq_t;
endpackage : btg_pkg
`default_nettype wire

// ==== src/btg_top.sv ====
// beep tone generator with playback mixer, mono routing and boot coefficient load
// Functional notes
// RQ1: nine 8-bit control registers 71 to 79
// RQ2: sine coefficient in registers 76 and 77
// RQ3: cosine coefficient in registers 78 and 79
// RQ4: 24-bit burst length in registers 73-75
// RQ5: one length count per sample period
// RQ6: reset to 0xEE, 0x10D8, 0x7EE3
// RQ7: left volume 6 bits, +2 to -61 dB
// RQ8: right volume independent, register 72 bits 5-0
// RQ9: register 72 bits 7-6 master volume
// RQ10: volume resets to +2 dB maximum
// RQ11: host zero-fills unused upper coefficient bits
// RQ12: host keeps tone below quarter sample rate
// RQ13: beep added after playback volume, before DAC
// RQ14: register 71 bit 7 enables generator
// RQ15: host mutes DAC around beep insertion
// RQ16: host avoids DAC clocks for serial clocks
// RQ17: reset copies passthrough biquads into RAM
// RQ18: boot copy lasts 100 microseconds
// RQ19: host leaves coefficient pages alone meanwhile
// RQ20: host loads coefficients before DAC power-up
// RQ21: register 63 bits 5-4 select mono input
// RQ22: rotation recurrence, self-clearing after burst
`timescale 1ns/1ps
`default_nettype none
`include "btg_defs.svh"

// ********************************
// playback fifo
// ********************************
module btg_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 4
) (
	input  wire logic         clock,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} btg_fifo_st_t;
	btg_fifo_st_t st_reg;
	btg_fifo_st_t st_next;
	logic         push;
	logic         pop;

	assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.cnt != '0);
	assign out_data  = st_reg.mem[st_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		st_next = st_reg;
		if (push)
		begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
		end
		if (pop)
			st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	a_fifo_count : assert property (@(posedge clock) disable iff (!arst_n)
		push && !pop |=> st_reg.cnt == $past(st_reg.cnt) + 1'b1)
		else $error("fifo count did not grow on push");
endmodule : btg_fifo

// ********************************
// generator top
// ********************************
module btg_top #(
	parameter int SAMPLE_DIV = `BTG_SAMPLE_DIV,
	parameter int COEF_WORDS = 60
) (
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	input  wire logic                  soft_reset,
	input  wire btg_pkg::btg_regreq_t  reg_req,
	output logic [7:0]                 reg_rdata,
	input  wire logic                  pb_valid,
	output logic                       pb_ready,
	input  wire btg_pkg::btg_play_t    pb_data,
	output logic signed [15:0]         dac_data,
	output logic                       dac_valid,
	output logic                       beep_active,
	output logic                       boot_busy,
	input  wire logic [5:0]            coef_raddr,
	output logic [23:0]                coef_rdata
);
	localparam int BOOT_CYC = `BTG_BOOT_CYC;
	localparam int CAW      = $clog2(COEF_WORDS);

	typedef struct packed {
		logic [7:0]         lctl;
		logic [7:0]         rctl;
		logic [7:0]         len_h;
		logic [7:0]         len_m;
		logic [7:0]         len_l;
		logic [7:0]         sin_h;
		logic [7:0]         sin_l;
		logic [7:0]         cos_h;
		logic [7:0]         cos_l;
		logic [7:0]         route;
		logic [7:0]         rdata;
		logic [23:0]        remain;
		logic               running;
		logic signed [15:0] xs;
		logic signed [15:0] ys;
		logic [15:0]        div;
		btg_pkg::btg_boot_t boot;
		logic [9:0]         boot_cnt;
		logic [CAW-1:0]     boot_idx;
		logic signed [15:0] dac;
		logic               dac_valid;
		logic [23:0]        coef_q;
	} btg_state_t;

	btg_state_t         st_reg;
	btg_state_t         st_next;
	logic [23:0]        coef_ram [COEF_WORDS];
	logic               tick;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic signed [15:0] fifo_out_data;
	logic signed [15:0] pb_mono;
	logic [23:0]        length;
	logic signed [15:0] sin_c;
	logic signed [15:0] cos_c;
	logic               wr71;
	logic signed [32:0] nx;
	logic signed [32:0] ny;
	logic signed [15:0] beep_l;
	logic signed [15:0] beep_r;
	logic signed [15:0] beep_m;
	logic signed [16:0] mix;

	// ********************************
	// helpers
	// ********************************
	function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sh7FFF)
			return 16'sh7FFF;
		else if (v < -34'sh8000)
			return -16'sh8000;
		else
			return v[15:0];
	endfunction : sat16

	// 00 left, 01 right, 10 average, 11 silent
	function automatic logic signed [15:0] route_sel(input logic [1:0] sel,
		input logic signed [15:0] l, input logic signed [15:0] r);
		logic signed [16:0] s;
		s = 17'(l) + 17'(r);
		unique case (sel)
			2'h0: return l;
			2'h1: return r;
			2'h2: return s[16:1];
			default: return 16'sh0000;
		endcase
	endfunction : route_sel

	// code 0 is +2 dB, every code 1 dB lower; master adds 6 dB steps
	function automatic logic signed [15:0] vol_scale(input logic signed [15:0] v,
		input logic [5:0] code, input logic [1:0] master);
		logic [15:0]        g;
		logic signed [33:0] p;
		logic [3:0]         sh;
		g = 16'h0000;
		unique case (code % 6'(`BTG_STEPS_OCT))
			6'h0: g = 16'h5092;
			6'h1: g = 16'h47CF;
			6'h2: g = 16'h4000;
			6'h3: g = 16'h390A;
			6'h4: g = 16'h32D6;
			default: g = 16'h2D4F;
		endcase
		sh = 4'(code / 6'(`BTG_STEPS_OCT)) + 4'(master);
		p = (34'(v) * $signed({18'h0, g})) >>> `BTG_VOL_FRAC;
		return sat16(p >>> sh);
	endfunction : vol_scale

	// ********************************
	// datapath
	// ********************************
	assign tick        = (st_reg.div == '0);
	assign length      = {st_reg.len_h, st_reg.len_m, st_reg.len_l}; // [RQ4]
	assign sin_c       = {st_reg.sin_h, st_reg.sin_l}; // [RQ2]
	assign cos_c       = {st_reg.cos_h, st_reg.cos_l}; // [RQ3]
	assign wr71        = reg_req.wr && reg_req.addr == `BTG_A_LCTL;
	assign pb_mono     = route_sel(st_reg.route[`BTG_ROUTE_HI:`BTG_ROUTE_LO],
		pb_data.left, pb_data.right); // [RQ21]
	// rotation by the programmed angle keeps amplitude without a table [RQ22]
	assign nx          = 33'((32'(st_reg.xs) * cos_c) - (32'(st_reg.ys) * sin_c));
	assign ny          = 33'((32'(st_reg.xs) * sin_c) + (32'(st_reg.ys) * cos_c));
	assign beep_l      = vol_scale(st_reg.ys, st_reg.lctl[5:0], st_reg.rctl[7:6]); // [RQ7] [RQ9]
	assign beep_r      = vol_scale(st_reg.ys, st_reg.rctl[5:0], st_reg.rctl[7:6]); // [RQ8] [RQ9]
	assign beep_m      = st_reg.running ? route_sel(st_reg.route[`BTG_ROUTE_HI:`BTG_ROUTE_LO],
		beep_l, beep_r) : 16'sh0000;
	// playback arrives already volume scaled, so only the beep gain applies here [RQ13]
	assign mix         = 17'(fifo_out_valid ? fifo_out_data : 16'sh0000) + 17'(beep_m);
	assign reg_rdata   = st_reg.rdata;
	assign dac_data    = st_reg.dac;
	assign dac_valid   = st_reg.dac_valid;
	assign beep_active = st_reg.running;
	assign boot_busy   = (st_reg.boot != btg_pkg::BTG_BOOT_DONE);
	assign coef_rdata  = st_reg.coef_q;
	assign pb_ready    = fifo_in_ready;

	btg_fifo #(
		.W     (16),
		.DEPTH (4)
	) u_fifo (
		.clock     (clock),
		.arst_n    (arst_n),
		.in_valid  (pb_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (pb_mono),
		.out_valid (fifo_out_valid),
		.out_ready (tick),
		.out_data  (fifo_out_data)
	);

	// ********************************
	// state update
	// ********************************
	always_comb
	begin
		st_next = st_reg;
		st_next.dac_valid = 1'b0;
		st_next.div = tick ? 16'(SAMPLE_DIV - 1) : st_reg.div - 1'b1;
		st_next.coef_q = boot_busy ? 24'h000000 : coef_ram[CAW'(coef_raddr)];

		// burst control, one count per sample [RQ5]
		if (st_reg.lctl[`BTG_EN_BIT] && !st_reg.running)
		begin
			st_next.xs = `BTG_ONE_Q15;
			st_next.ys = 16'sh0000;
			st_next.remain = length;
			st_next.running = (length != '0);
			if (length == '0)
				st_next.lctl[`BTG_EN_BIT] = 1'b0;
		end
		else if (st_reg.running && !st_reg.lctl[`BTG_EN_BIT])
			st_next.running = 1'b0;
		else if (st_reg.running && tick)
		begin
			st_next.xs = sat16(34'(nx >>> 15));
			st_next.ys = sat16(34'(ny >>> 15));
			st_next.remain = st_reg.remain - 1'b1;
			if (st_reg.remain == 24'h000001)
			begin
				st_next.running = 1'b0;
				st_next.lctl[`BTG_EN_BIT] = 1'b0; // [RQ22]
			end
		end

		if (tick)
		begin
			st_next.dac = sat16(34'(mix));
			st_next.dac_valid = 1'b1;
		end

		// boot copy of passthrough coefficients [RQ17] [RQ18]
		if (boot_busy)
			st_next.boot_cnt = st_reg.boot_cnt + 1'b1;
		unique case (st_reg.boot)
			btg_pkg::BTG_BOOT_COPY:
			begin
				st_next.boot_idx = st_reg.boot_idx + 1'b1;
				if (st_reg.boot_idx == CAW'(COEF_WORDS - 1))
					st_next.boot = btg_pkg::BTG_BOOT_WAIT;
			end
			btg_pkg::BTG_BOOT_WAIT:
			begin
				if (st_reg.boot_cnt == 10'(BOOT_CYC - 1))
					st_next.boot = btg_pkg::BTG_BOOT_DONE;
			end
			btg_pkg::BTG_BOOT_DONE: ;
			default: st_next.boot = btg_pkg::BTG_BOOT_COPY;
		endcase

		// host access; a host write lands after the self-clear, so it wins [RQ1]
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				`BTG_A_LCTL:  st_next.rdata = st_reg.lctl;
				`BTG_A_RCTL:  st_next.rdata = st_reg.rctl;
				`BTG_A_LEN_H: st_next.rdata = st_reg.len_h;
				`BTG_A_LEN_M: st_next.rdata = st_reg.len_m;
				`BTG_A_LEN_L: st_next.rdata = st_reg.len_l;
				`BTG_A_SIN_H: st_next.rdata = st_reg.sin_h;
				`BTG_A_SIN_L: st_next.rdata = st_reg.sin_l;
				`BTG_A_COS_H: st_next.rdata = st_reg.cos_h;
				`BTG_A_COS_L: st_next.rdata = st_reg.cos_l;
				`BTG_A_ROUTE: st_next.rdata = st_reg.route;
				default:      st_next.rdata = `BTG_R_ZERO;
			endcase
		end
		if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				`BTG_A_LCTL:  st_next.lctl = reg_req.wdata; // [RQ14]
				`BTG_A_RCTL:  st_next.rctl = reg_req.wdata;
				`BTG_A_LEN_H: st_next.len_h = reg_req.wdata;
				`BTG_A_LEN_M: st_next.len_m = reg_req.wdata;
				`BTG_A_LEN_L: st_next.len_l = reg_req.wdata;
				`BTG_A_SIN_H: st_next.sin_h = reg_req.wdata;
				`BTG_A_SIN_L: st_next.sin_l = reg_req.wdata;
				`BTG_A_COS_H: st_next.cos_h = reg_req.wdata;
				`BTG_A_COS_L: st_next.cos_l = reg_req.wdata;
				`BTG_A_ROUTE: st_next.route = reg_req.wdata;
				default: ;
			endcase
		end

		if (soft_reset)
		begin
			st_next = '0;
			st_next.len_l = `BTG_R_LEN_L;
			st_next.sin_h = `BTG_R_SIN_H;
			st_next.sin_l = `BTG_R_SIN_L;
			st_next.cos_h = `BTG_R_COS_H;
			st_next.cos_l = `BTG_R_COS_L;
			st_next.boot = btg_pkg::BTG_BOOT_COPY;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg <= '0; // volume codes 0 give +2 dB, the loudest setting [RQ10]
			st_reg.len_l <= `BTG_R_LEN_L; // [RQ6]
			st_reg.sin_h <= `BTG_R_SIN_H;
			st_reg.sin_l <= `BTG_R_SIN_L;
			st_reg.cos_h <= `BTG_R_COS_H;
			st_reg.cos_l <= `BTG_R_COS_L;
			st_reg.boot <= btg_pkg::BTG_BOOT_COPY;
		end
		else
			st_reg <= st_next;
	end

	// the ram has no reset; its contents are only trusted after the copy
	always_ff @(posedge clock)
	begin
		if (st_reg.boot == btg_pkg::BTG_BOOT_COPY)
			coef_ram[st_reg.boot_idx] <= (32'(st_reg.boot_idx) % `BTG_TAPS == 0) ?
				`BTG_PASS_COEF : 24'h000000; // [RQ17]
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_enable_write;
		wr71 && reg_req.wdata[`BTG_EN_BIT] && !st_reg.running && length != '0 && !soft_reset;
	endsequence
	sequence s_started;
		st_reg.running && st_reg.ys == 16'sh0000 ##0 st_reg.remain == length;
	endsequence

	a_enable_starts : assert property (s_enable_write ##1 !soft_reset && !reg_req.wr
		|=> s_started) // [RQ14]
		else $error("burst did not start after enable");
	a_sine_write : assert property (reg_req.wr && reg_req.addr == `BTG_A_SIN_H && !soft_reset
		|=> st_reg.sin_h == $past(reg_req.wdata)) // [RQ2]
		else $error("sine high byte not stored");
	a_cosine_write : assert property (reg_req.wr && reg_req.addr == `BTG_A_COS_L && !soft_reset
		|=> cos_c[7:0] == $past(reg_req.wdata)) // [RQ3]
		else $error("cosine low byte not stored");
	a_burst_count : assert property (st_reg.running && st_reg.lctl[`BTG_EN_BIT] && tick
		&& st_reg.remain > 24'h000001 && !soft_reset
		|=> st_reg.remain == $past(st_reg.remain) - 1'b1) // [RQ5]
		else $error("burst counter did not step per sample");
	a_burst_end : assert property (st_reg.running && st_reg.lctl[`BTG_EN_BIT] && tick
		&& st_reg.remain == 24'h000001 && !wr71 && !soft_reset
		|=> !st_reg.running && !st_reg.lctl[`BTG_EN_BIT]) // [RQ22]
		else $error("burst did not end and self-clear");
	a_boot_holds : assert property (boot_busy && st_reg.boot_cnt < 10'(BOOT_CYC - 1)
		&& !soft_reset |=> boot_busy) // [RQ18]
		else $error("boot copy ended early");
	a_boot_ends : assert property (boot_busy && st_reg.boot_cnt == 10'(BOOT_CYC - 1)
		&& !soft_reset |=> !boot_busy [*2]) // [RQ18]
		else $error("boot copy overran");
	a_dac_cadence : assert property (tick && !soft_reset |=> dac_valid
		##1 !dac_valid) // [RQ13]
		else $error("dac sample not produced once per tick");
	a_silent_mix : assert property (tick && !st_reg.running && !fifo_out_valid && !soft_reset
		|=> dac_data == 16'sh0000) // [RQ13]
		else $error("idle mixer output not zero");
	a_route_right : assert property (pb_valid && pb_ready
		&& st_reg.route[`BTG_ROUTE_HI:`BTG_ROUTE_LO] == 2'h1 |-> pb_mono == pb_data.right) // [RQ21]
		else $error("mono route right not selected");
endmodule : btg_top
`default_nettype wire

// ==== tb/btg_host.sv ====
// host-side register master model for the beep tone generator
`timescale 1ns/1ps
`default_nettype none

module btg_host (
	input  wire logic                 clock,
	output var  btg_pkg::btg_regreq_t reg_req,
	input  wire logic [7:0]           reg_rdata
);
	// **********************
	// register access
	// **********************
	// only whole bytes are written, so unused upper field bits go out as zeros
	// tones are set up below a quarter of the sample rate, defaults only
	// no coefficient page access while the boot copy runs
	// dac mute and divider steps live outside this block
	initial
	begin
		reg_req = '0;
	end

	// released address and data are inverted so a stale value never looks valid
	task automatic put(input logic [7:0] addr, input logic [7:0] data, input logic wr);
		@(negedge clock);
		reg_req.addr  = addr;
		reg_req.wdata = data;
		reg_req.wr    = wr;
		reg_req.rd    = ~wr;
		@(negedge clock);
		reg_req       = {~addr, ~data, 2'b00};
	endtask : put

	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		put(addr, data, 1'b1);
	endtask : write

	task automatic read(input logic [7:0] addr, output logic [7:0] data);
		put(addr, 8'h00, 1'b0);
		@(negedge clock);
		data = reg_rdata;
	endtask : read
endmodule : btg_host

`default_nettype wire

// ==== tb/beep_tone_generator_bench.sv ====
// self-checking bench of the beep tone generator
`timescale 1ns/1ps
`default_nettype none

module beep_tone_generator_bench;
	localparam int DIV = 8;
	logic                 clock = 1'b0;
	logic                 arst_n;
	logic                 soft_reset;
	btg_pkg::btg_regreq_t reg_req;
	logic [7:0]           reg_rdata;
	logic                 pb_valid;
	logic                 pb_ready;
	btg_pkg::btg_play_t   pb_data;
	logic signed [15:0]   dac_data;
	logic                 dac_valid;
	logic                 beep_active;
	logic                 boot_busy;
	logic [5:0]           coef_raddr;
	logic [23:0]          coef_rdata;
	int                   num_errors = 0;
	int                   num_checks = 0;
	int                   i;
	int                   act;
	int                   heard;
	int                   pk    [4];
	logic                 full;
	logic [7:0]           d;
	logic [7:0]           addrs [10] = '{8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B,
		8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h3F};
	logic [7:0]           rst_v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hEE,
		8'h10, 8'hD8, 8'h7E, 8'hE3, 8'h00};
	logic [7:0]           pat   [10] = '{8'h3F, 8'hFF, 8'h01, 8'h23, 8'h45,
		8'h67, 8'h89, 8'hAB, 8'hCD, 8'h30};
	logic [15:0]          mono  [4]  = '{16'h1000, 16'h3000, 16'h2000, 16'h0000};

	always #50 clock = ~clock;

	btg_top #(.SAMPLE_DIV(DIV), .COEF_WORDS(60)) i_btg_top (
		.clock(clock), .arst_n(arst_n), .soft_reset(soft_reset), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .pb_valid(pb_valid), .pb_ready(pb_ready),
		.pb_data(pb_data), .dac_data(dac_data), .dac_valid(dac_valid),
		.beep_active(beep_active), .boot_busy(boot_busy), .coef_raddr(coef_raddr),
		.coef_rdata(coef_rdata)
	);

	btg_host i_btg_host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));

	// **********************
	// helpers
	// **********************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	// bounded wait for the next sample pulse, looked at in its own cycle
	task automatic wait_tick;
		int n;
		n = 0;
		@(negedge clock);
		while (dac_valid !== 1'b1 && n < 4 * DIV)
		begin
			@(negedge clock);
			n++;
		end
		check(dac_valid, 1'b1);
	endtask : wait_tick

	// enables a burst and counts active cycles and audible samples
	task automatic burst(input logic [7:0] len);
		act   = 0;
		heard = 0;
		i_btg_host.write(8'h4B, len);
		i_btg_host.write(8'h47, 8'h80);
		repeat (12 * DIV)
		begin
			@(negedge clock);
			if (beep_active === 1'b1)
				act++;
			if (dac_valid === 1'b1 && dac_data !== 16'h0000)
				heard++;
		end
		i_btg_host.read(8'h47, d);
		check(d, 8'h00);
	endtask : burst

	// plays a short burst and keeps the largest sample heard
	task automatic peak(input logic [7:0] ctl, input logic [7:0] mst, output int pk_seen);
		pk_seen = 0;
		i_btg_host.write(8'h48, mst);
		i_btg_host.write(8'h47, ctl);
		repeat (30 * DIV)
		begin
			@(negedge clock);
			if (dac_valid === 1'b1 && int'(dac_data) > pk_seen)
				pk_seen = int'(dac_data);
		end
	endtask : peak

	// **********************
	// watchdog
	// **********************
	// the run needs about 3600 cycles, so over five times that means a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		num_errors++;
		end_sim();
	end

	// **********************
	// tests
	// **********************
	initial
	begin
		arst_n     = 1'b0;
		soft_reset = 1'b0;
		pb_valid   = 1'b0;
		pb_data    = '0;
		coef_raddr = 6'h00;
		repeat (20) @(negedge clock);
		arst_n = 1'b1;
		repeat (990) @(negedge clock);
		check(boot_busy, 1'b1);
		repeat (20) @(negedge clock);
		check(boot_busy, 1'b0);
		for (i = 0; i < 10; i++)
		begin
			i_btg_host.write(addrs[i], pat[i]);
			i_btg_host.read(addrs[i], d);
			check(d, pat[i]);
		end
		i_btg_host.write(8'h50, 8'h5A);
		i_btg_host.read(8'h50, d);
		check(d, 8'h00);
		@(negedge clock);
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		@(negedge clock);
		check(boot_busy, 1'b1);
		repeat (1010) @(negedge clock);
		for (i = 0; i < 10; i++)
		begin
			i_btg_host.read(addrs[i], d);
			check(d, rst_v[i]);
		end
		for (i = 0; i < 10; i++)
		begin
			coef_raddr = i[5:0];
			@(negedge clock);
			check(coef_rdata, (i % 5 == 0) ? 24'h7FFFFF : 24'h000000);
		end
		burst(8'h05);
		check(act > 4 * DIV && act <= 5 * DIV, 1'b1);
		check(heard > 0, 1'b1);
		burst(8'h00);
		check(act, 0);
		i_btg_host.write(8'h4A, 8'h01);
		i_btg_host.write(8'h47, 8'h80);
		repeat (4) @(negedge clock);
		check(beep_active, 1'b1);
		i_btg_host.write(8'h47, 8'h00);
		repeat (2) @(negedge clock);
		check(beep_active, 1'b0);
		// same sample held on the stream so every word in the fifo matches
		for (i = 0; i < 4; i++)
		begin
			i_btg_host.write(8'h3F, {2'b00, i[1:0], 4'h0});
			pb_data  = {16'sh1000, 16'sh3000};
			pb_valid = 1'b1;
			full     = 1'b0;
			repeat (12) @(negedge clock)
				if (pb_ready === 1'b0)
					full = 1'b1;
			pb_valid = 1'b0;
			check(full, 1'b1);
			wait_tick();
			check(dac_data, mono[i]);
			repeat (5) wait_tick();
			wait_tick();
			check(dac_data, 16'h0000);
		end
		// 0 dB reference against 6 dB cuts by left code, master and right code
		i_btg_host.write(8'h3F, 8'h00);
		i_btg_host.write(8'h4A, 8'h00);
		i_btg_host.write(8'h4B, 8'h18);
		peak(8'h82, 8'h00, pk[0]);
		peak(8'h88, 8'h00, pk[1]);
		peak(8'h82, 8'h40, pk[2]);
		i_btg_host.write(8'h3F, 8'h10);
		peak(8'hBF, 8'h08, pk[3]);
		check(pk[0] > 16'h4000, 1'b1);
		check(pk[1] >= pk[0] / 2 - 1 && pk[1] <= pk[0] / 2 + 1, 1'b1);
		check(pk[2] >= pk[0] / 2 - 1 && pk[2] <= pk[0] / 2 + 1, 1'b1);
		check(pk[3] >= pk[0] / 2 - 1 && pk[3] <= pk[0] / 2 + 1, 1'b1);
		end_sim();
	end
endmodule : beep_tone_generator_bench

`default_nettype wire
